// ---- sfr_pkg.sv ----
package sfr_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_ENABLE_LO = 8'h00;
    localparam logic [7:0] ADDR_ENABLE_HI = 8'h01;
    localparam logic [7:0] ADDR_FLAG_LO = 8'h02;
    localparam logic [7:0] ADDR_FLAG_HI = 8'h03;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h05;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h06;

    // ----------------------------------------
    // enable register fields
    // ----------------------------------------
    localparam int BIT_WDOG_IRQ_EN = 0;
    localparam int BIT_OSC_FAULT_IRQ_EN = 1;
    localparam int BIT_PIN_NMI_IRQ_EN = 4;
    localparam int BIT_FLASH_VIOLATION_IRQ_EN = 5;
    localparam logic [7:0] ENABLE_MASK = 8'h33;
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    // ----------------------------------------
    // flag register fields
    // ----------------------------------------
    localparam int BIT_WDOG_FLAG = 0;
    localparam int BIT_OSC_FAULT_FLAG = 1;
    localparam int BIT_POWER_ON_FLAG = 2;
    localparam int BIT_EXT_RESET_FLAG = 3;
    localparam int BIT_PIN_NMI_FLAG = 4;
    localparam logic [7:0] FLAG_MASK = 8'h1F;
    localparam logic [7:0] FLAG_POR_MASK = 8'h0D;
    localparam logic [7:0] FLAG_POR_RESET = 8'h04;
    localparam logic [7:0] FLAG_CLR_MASK = 8'h12;
    localparam logic [7:0] FLAG_CLR_RESET = 8'h02;

    // ----------------------------------------
    // event interrupt layout
    // ----------------------------------------
    localparam int NUM_EVENTS = 4;
    localparam int EVT_OSC_FAULT = 0;
    localparam int EVT_PIN_NMI = 1;
    localparam int EVT_FLASH_VIOLATION = 2;
    localparam int EVT_WDOG_INTERVAL = 3;
    localparam logic [3:0] EVT_RESET = 4'h0;
    localparam logic [15:0] NMI_VECTOR_ADDR = 16'hFFFC;
endpackage : sfr_pkg

// ---- sfr_event_if.sv ----
interface sfr_event_if;
    logic [3:0] event_pulse;
    logic [7:0] clear_bits;
    logic clear_we;
    logic [7:0] enable_bits;
    logic enable_we;
    logic [3:0] status;
    logic [3:0] enable;
    logic irq;

    modport bank
    (
        output event_pulse,
        output clear_bits,
        output clear_we,
        output enable_bits,
        output enable_we,
        input status,
        input enable,
        input irq
    );

    modport ctrl
    (
        input event_pulse,
        input clear_bits,
        input clear_we,
        input enable_bits,
        input enable_we,
        output status,
        output enable,
        output irq
    );
endinterface : sfr_event_if

// ---- sfr_irq_ctrl.sv ----
module sfr_irq_ctrl
(
    input wire logic clk_sys_i, // system clock
    input wire logic resetn_i, // sync reset, active low
    sfr_event_if.ctrl ev // event/irq channel
);
    logic [3:0] status_reg;
    logic [3:0] status_next;
    logic [3:0] enable_reg;
    logic [3:0] enable_next;
    logic irq_reg;
    logic irq_next;

    always_comb
    begin
        // set wins over a same-cycle clear
        status_next = status_reg;
        if (ev.clear_we)
        begin
            status_next = status_reg & ~ev.clear_bits[3:0];
        end
        status_next = status_next | ev.event_pulse;
        enable_next = ev.enable_we ? ev.enable_bits[3:0] : enable_reg;
        irq_next = |(status_next & enable_next);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            status_reg <= sfr_pkg::EVT_RESET;
            enable_reg <= sfr_pkg::EVT_RESET;
            irq_reg <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            enable_reg <= enable_next;
            irq_reg <= irq_next;
        end
    end

    assign ev.status = status_reg;
    assign ev.enable = enable_reg;
    assign ev.irq = irq_reg;

    a_irq_follows_status: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        irq_reg == |(status_reg & enable_reg))
        else $error("irq level does not match status and enable");
endmodule : sfr_irq_ctrl

// ---- sfr_bank.sv ----
// Operation
// - unassigned bit positions hold no storage.
// - enable byte 00h: bits 0,1,4,5, cleared by power-up-clear reset.
// - watchdog enable gates watchdog irq only in interval timer mode.
// - flag byte 02h: watchdog, osc fault, power-on, ext reset, pin nmi.
// - all implemented enable and flag bits are read/write.
// - power-on reset sets power-on flag, clears watchdog and ext reset flags.
// - power-up-clear reset sets osc fault flag, clears pin nmi flag.
// - oscillator fault detection sets osc fault flag.
// - power-on reset event sets power-on flag.
// - pin reset in reset mode sets ext reset flag; power-on reset clears it.
// - pin nmi event sets pin nmi flag.
// - osc, nmi, flash events gated only by own enable; shared vector.
//
// Design decision made here: the strobed register port.
module sfr_bank
(
    input wire logic clk_sys_i, // system clock, 40 MHz
    input wire logic resetn_i, // power-up-clear reset, sync, active low
    input wire logic por_n_i, // power-on reset, sync, active low
    input wire logic [7:0] addr_i, // register byte address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    input wire logic osc_fault_i, // oscillator fault detected
    input wire logic wdog_event_i, // watchdog expiry event
    input wire logic wdog_interval_mode_i, // 1: interval timer, 0: watchdog mode
    input wire logic pin_reset_i, // reset seen on shared pin in reset mode
    input wire logic pin_nmi_i, // nmi event on shared pin
    input wire logic flash_violation_i, // flash access violation flag level
    output logic nmi_req_o, // request to the nmi vector
    output logic wdog_irq_o, // maskable watchdog interval request
    output logic irq_o // level interrupt of the event status block
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] enable_reg;
    logic [7:0] enable_next;
    logic [7:0] flag_reg;
    logic [7:0] flag_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic nmi_req_reg;
    logic nmi_req_next;
    logic wdog_irq_reg;
    logic wdog_irq_next;
    logic [7:0] hw_set;
    logic flash_prev_reg;
    logic pwr_clear_n;

    sfr_event_if ev ();

    // a power-on reset must clear the event block as well
    assign pwr_clear_n = resetn_i & por_n_i;

    sfr_irq_ctrl u_irq
    (
        .clk_sys_i(clk_sys_i),
        .resetn_i(pwr_clear_n),
        .ev(ev)
    );

    // ----------------------------------------
    // hardware event sources
    // ----------------------------------------
    always_comb
    begin
        hw_set = 8'h00;
        hw_set[sfr_pkg::BIT_WDOG_FLAG] = wdog_event_i;
        hw_set[sfr_pkg::BIT_OSC_FAULT_FLAG] = osc_fault_i;
        hw_set[sfr_pkg::BIT_EXT_RESET_FLAG] = pin_reset_i;
        hw_set[sfr_pkg::BIT_PIN_NMI_FLAG] = pin_nmi_i;
    end

    // ----------------------------------------
    // register next values
    // ----------------------------------------
    always_comb
    begin
        enable_next = enable_reg;
        flag_next = flag_reg;
        if (wr_i && addr_i == sfr_pkg::ADDR_ENABLE_LO)
        begin
            enable_next = wdata_i & sfr_pkg::ENABLE_MASK;
        end
        if (wr_i && addr_i == sfr_pkg::ADDR_FLAG_LO)
        begin
            flag_next = wdata_i & sfr_pkg::FLAG_MASK;
        end
        // hardware set applied last so it wins over a write of zero
        flag_next = (flag_next | hw_set) & sfr_pkg::FLAG_MASK;
        enable_next = enable_next & sfr_pkg::ENABLE_MASK;
    end

    always_comb
    begin
        rdata_next = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                sfr_pkg::ADDR_ENABLE_LO: rdata_next = enable_reg;
                sfr_pkg::ADDR_FLAG_LO: rdata_next = flag_reg;
                sfr_pkg::ADDR_IRQ_STATUS: rdata_next = {4'h0, ev.status};
                sfr_pkg::ADDR_IRQ_ENABLE: rdata_next = {4'h0, ev.enable};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // request outputs
    // ----------------------------------------
    always_comb
    begin
        // global interrupt enable is not consulted here
        nmi_req_next = (flag_reg[sfr_pkg::BIT_OSC_FAULT_FLAG]
            & enable_reg[sfr_pkg::BIT_OSC_FAULT_IRQ_EN])
            | (flag_reg[sfr_pkg::BIT_PIN_NMI_FLAG]
            & enable_reg[sfr_pkg::BIT_PIN_NMI_IRQ_EN])
            | (flash_violation_i
            & enable_reg[sfr_pkg::BIT_FLASH_VIOLATION_IRQ_EN]);
        wdog_irq_next = wdog_interval_mode_i
            & flag_reg[sfr_pkg::BIT_WDOG_FLAG]
            & enable_reg[sfr_pkg::BIT_WDOG_IRQ_EN];
    end

    // ----------------------------------------
    // event status block feed
    // ----------------------------------------
    always_comb
    begin
        ev.event_pulse = 4'h0;
        ev.event_pulse[sfr_pkg::EVT_OSC_FAULT] = osc_fault_i
            & ~flag_reg[sfr_pkg::BIT_OSC_FAULT_FLAG];
        ev.event_pulse[sfr_pkg::EVT_PIN_NMI] = pin_nmi_i;
        ev.event_pulse[sfr_pkg::EVT_FLASH_VIOLATION] = flash_violation_i & ~flash_prev_reg;
        ev.event_pulse[sfr_pkg::EVT_WDOG_INTERVAL] = wdog_event_i & wdog_interval_mode_i;
        ev.clear_bits = wdata_i;
        ev.clear_we = wr_i && addr_i == sfr_pkg::ADDR_IRQ_CLEAR;
        ev.enable_bits = wdata_i;
        ev.enable_we = wr_i && addr_i == sfr_pkg::ADDR_IRQ_ENABLE;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        // power-on bits follow only por_n_i, the rest both por_n_i and the power-up clear
        if (!por_n_i)
        begin
            flag_reg[sfr_pkg::BIT_WDOG_FLAG] <= 1'b0;
            flag_reg[sfr_pkg::BIT_POWER_ON_FLAG] <= 1'b1;
            flag_reg[sfr_pkg::BIT_EXT_RESET_FLAG] <= 1'b0;
        end
        else
        begin
            flag_reg[sfr_pkg::BIT_WDOG_FLAG] <= flag_next[sfr_pkg::BIT_WDOG_FLAG];
            flag_reg[sfr_pkg::BIT_POWER_ON_FLAG] <= flag_next[sfr_pkg::BIT_POWER_ON_FLAG];
            flag_reg[sfr_pkg::BIT_EXT_RESET_FLAG] <= flag_next[sfr_pkg::BIT_EXT_RESET_FLAG];
        end
        if (!resetn_i || !por_n_i)
        begin
            enable_reg <= sfr_pkg::ENABLE_RESET;
            flag_reg[sfr_pkg::BIT_OSC_FAULT_FLAG] <= 1'b1;
            flag_reg[sfr_pkg::BIT_PIN_NMI_FLAG] <= 1'b0;
            rdata_reg <= 8'h00;
            nmi_req_reg <= 1'b0;
            wdog_irq_reg <= 1'b0;
            flash_prev_reg <= 1'b0;
        end
        else
        begin
            enable_reg <= enable_next;
            flag_reg[sfr_pkg::BIT_OSC_FAULT_FLAG] <= flag_next[sfr_pkg::BIT_OSC_FAULT_FLAG];
            flag_reg[sfr_pkg::BIT_PIN_NMI_FLAG] <= flag_next[sfr_pkg::BIT_PIN_NMI_FLAG];
            rdata_reg <= rdata_next;
            nmi_req_reg <= nmi_req_next;
            wdog_irq_reg <= wdog_irq_next;
            flash_prev_reg <= flash_violation_i;
        end
        // unimplemented flag bits hold no storage
        flag_reg[7:5] <= 3'h0;
    end

    assign rdata_o = rdata_reg;
    assign nmi_req_o = nmi_req_reg;
    assign wdog_irq_o = wdog_irq_reg;
    assign irq_o = ev.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_flag_write_zero;
        wr_i && addr_i == sfr_pkg::ADDR_FLAG_LO && !wdata_i[sfr_pkg::BIT_PIN_NMI_FLAG];
    endsequence

    a_enable_reset_zero: assert property (@(posedge clk_sys_i)
        !resetn_i |=> enable_reg == 8'h00)
        else $error("enable register not cleared by reset");

    a_wdog_mode_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !wdog_interval_mode_i |=> !wdog_irq_o)
        else $error("watchdog irq in watchdog mode");

    a_por_flags: assert property (@(posedge clk_sys_i)
        !por_n_i |=> flag_reg[4:0] == 5'h06)
        else $error("power-on reset flag values wrong");

    a_clear_flags: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        !resetn_i |=> flag_reg[sfr_pkg::BIT_OSC_FAULT_FLAG] && !flag_reg[sfr_pkg::BIT_PIN_NMI_FLAG])
        else $error("power-up-clear flag values wrong");

    a_clear_keeps_power: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        !resetn_i |=> $stable(flag_reg[sfr_pkg::BIT_POWER_ON_FLAG]))
        else $error("power-on flag disturbed by power-up clear");

    a_osc_sets_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i || !por_n_i)
        osc_fault_i |=> flag_reg[sfr_pkg::BIT_OSC_FAULT_FLAG])
        else $error("osc fault flag not set");

    a_set_beats_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i || !por_n_i)
        s_flag_write_zero and pin_nmi_i |=> flag_reg[sfr_pkg::BIT_PIN_NMI_FLAG])
        else $error("nmi flag lost to software clear");

    a_reserved_reads: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_i && (addr_i == sfr_pkg::ADDR_ENABLE_HI || addr_i == sfr_pkg::ADDR_FLAG_HI)
        |=> rdata_o == 8'h00)
        else $error("reserved byte reads nonzero");

    a_nmi_request: assert property (@(posedge clk_sys_i) disable iff (!resetn_i || !por_n_i)
        flag_reg[sfr_pkg::BIT_PIN_NMI_FLAG] && enable_reg[sfr_pkg::BIT_PIN_NMI_IRQ_EN]
        |=> nmi_req_o)
        else $error("nmi request not raised");

    a_enable_readback: assert property (@(posedge clk_sys_i) disable iff (!resetn_i || !por_n_i)
        wr_i && addr_i == sfr_pkg::ADDR_ENABLE_LO ##1 rd_i && addr_i == sfr_pkg::ADDR_ENABLE_LO
        |=> rdata_o == ($past(wdata_i, 2) & 8'h33))
        else $error("enable readback mismatch");

    // ----------------------------------------
    // storage, access and request checks
    // ----------------------------------------
    sequence s_no_flag_event;
        !osc_fault_i && !wdog_event_i && !pin_reset_i && !pin_nmi_i;
    endsequence

    // clear-only reset with no bus write and no set source on these bits
    sequence s_clear_only;
        !resetn_i && por_n_i && !wr_i && !wdog_event_i && !pin_reset_i;
    endsequence

    a_enable_spare_zero: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) enable_reg[7:6] == 2'h0 && enable_reg[3:2] == 2'h0)
        else $error("unassigned enable bits hold a value");

    a_flag_spare_zero: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) flag_reg[7:5] == 3'h0)
        else $error("unassigned flag bits hold a value");

    a_enable_write_lands: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) wr_i && addr_i == sfr_pkg::ADDR_ENABLE_LO
        |=> enable_reg == ($past(wdata_i) & sfr_pkg::ENABLE_MASK))
        else $error("enable write did not land");

    a_flag_write_lands: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) (wr_i && addr_i == sfr_pkg::ADDR_FLAG_LO) ##0 s_no_flag_event
        |=> flag_reg == ($past(wdata_i) & sfr_pkg::FLAG_MASK))
        else $error("flag write did not land");

    a_enable_hold: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) !(wr_i && addr_i == sfr_pkg::ADDR_ENABLE_LO)
        |=> $stable(enable_reg))
        else $error("enable changed without a write");

    a_flag_hold: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) !wr_i ##0 s_no_flag_event |=> $stable(flag_reg))
        else $error("flag changed without a write or event");

    a_wdog_sets_flag: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) wdog_event_i |=> flag_reg[sfr_pkg::BIT_WDOG_FLAG])
        else $error("watchdog flag not set");

    a_pin_reset_flag: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) pin_reset_i |=> flag_reg[sfr_pkg::BIT_EXT_RESET_FLAG])
        else $error("external reset flag not set");

    a_pin_nmi_flag: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) pin_nmi_i |=> flag_reg[sfr_pkg::BIT_PIN_NMI_FLAG])
        else $error("pin nmi flag not set");

    a_por_sets_flag: assert property (@(posedge clk_sys_i)
        !por_n_i |=> flag_reg[sfr_pkg::BIT_POWER_ON_FLAG])
        else $error("power-on flag not set by power-on reset");

    a_por_clears_enable: assert property (@(posedge clk_sys_i)
        !por_n_i |=> enable_reg == sfr_pkg::ENABLE_RESET)
        else $error("enable register not cleared by power-on reset");

    a_clear_keeps_bits: assert property (@(posedge clk_sys_i)
        disable iff (!por_n_i) s_clear_only
        |=> $stable(flag_reg[sfr_pkg::BIT_WDOG_FLAG])
        && $stable(flag_reg[sfr_pkg::BIT_EXT_RESET_FLAG]))
        else $error("power-on bits disturbed by clear reset");

    a_read_idle_zero: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");

    a_read_enable: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) rd_i && addr_i == sfr_pkg::ADDR_ENABLE_LO
        |=> rdata_o == $past(enable_reg))
        else $error("enable read data wrong");

    a_read_flags: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) rd_i && addr_i == sfr_pkg::ADDR_FLAG_LO
        |=> rdata_o == $past(flag_reg))
        else $error("flag read data wrong");

    a_osc_request: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) flag_reg[sfr_pkg::BIT_OSC_FAULT_FLAG]
        && enable_reg[sfr_pkg::BIT_OSC_FAULT_IRQ_EN] |=> nmi_req_o)
        else $error("osc fault request not raised");

    a_flash_request: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) flash_violation_i
        && enable_reg[sfr_pkg::BIT_FLASH_VIOLATION_IRQ_EN] |=> nmi_req_o)
        else $error("flash violation request not raised");

    a_request_quiet: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n)
        !(flag_reg[sfr_pkg::BIT_OSC_FAULT_FLAG] && enable_reg[sfr_pkg::BIT_OSC_FAULT_IRQ_EN])
        && !(flag_reg[sfr_pkg::BIT_PIN_NMI_FLAG] && enable_reg[sfr_pkg::BIT_PIN_NMI_IRQ_EN])
        && !(flash_violation_i && enable_reg[sfr_pkg::BIT_FLASH_VIOLATION_IRQ_EN])
        |=> !nmi_req_o)
        else $error("request raised with no enabled source");

    a_wdog_irq_on: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) wdog_interval_mode_i && flag_reg[sfr_pkg::BIT_WDOG_FLAG]
        && enable_reg[sfr_pkg::BIT_WDOG_IRQ_EN] |=> wdog_irq_o)
        else $error("interval watchdog irq not raised");

    a_wdog_enable_gate: assert property (@(posedge clk_sys_i)
        disable iff (!pwr_clear_n) !enable_reg[sfr_pkg::BIT_WDOG_IRQ_EN] |=> !wdog_irq_o)
        else $error("watchdog irq raised while disabled");
endmodule : sfr_bank

// ---- system_interrupt_enable_flag_regs_tb.sv ----
module system_interrupt_enable_flag_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic por_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [4:0] hw_ev = 5'h00;
    logic mode_i = 1'b1;
    logic flash_i = 1'b0;
    logic [7:0] rdata_o;
    logic nmi_req_o;
    logic wdog_irq_o;
    logic irq_o;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    sfr_bank sfr_bank_inst
    (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .por_n_i(por_n_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .osc_fault_i(hw_ev[1]),
        .wdog_event_i(hw_ev[0]),
        .wdog_interval_mode_i(mode_i),
        .pin_reset_i(hw_ev[3]),
        .pin_nmi_i(hw_ev[4]),
        .flash_violation_i(flash_i),
        .nmi_req_o(nmi_req_o),
        .wdog_irq_o(wdog_irq_o),
        .irq_o(irq_o)
    );

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys_i)
    begin
        if (rd_d)
        begin
            if (exp_q.size() == 0)
                check_byte(rdata_o, 8'hXX);
            else
                check_byte(rdata_o, exp_q.pop_front());
        end
        rd_d <= rd_i;
    end

    // a hang is cut short well beyond the roughly 180 cycles expected
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // bus and event drivers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        addr_i <= a;
        exp_q.push_back(e);
        @(posedge clk_sys_i);
    endtask : rd

    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
    endtask : idle

    // outputs are levels registered late, so give them time to land
    task automatic settle;
        idle(3);
        #1;
    endtask : settle

    // strobes drop here so a preceding read is not issued twice
    task automatic pulse(input logic [4:0] m);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        hw_ev <= m;
        @(posedge clk_sys_i);
        hw_ev <= 5'h00;
    endtask : pulse

    task automatic reset_pulse(input logic clr, input logic pwr);
        idle(1);
        resetn_i <= ~clr;
        por_n_i <= ~pwr;
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        por_n_i <= 1'b1;
        @(posedge clk_sys_i);
    endtask : reset_pulse

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] d;
        logic [7:0] a;
        logic [7:0] en_tab[3];
        logic [7:0] fl_tab[3];
        logic [4:0] ev_tab[4];
        en_tab = '{8'h02, 8'h10, 8'h20};
        fl_tab = '{8'h02, 8'h10, 8'h00};
        ev_tab = '{5'h01, 5'h02, 5'h08, 5'h10};
        void'($urandom(32'hAA0C1BAD));
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        por_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(sfr_pkg::ADDR_ENABLE_LO, 8'h00);
        rd(sfr_pkg::ADDR_ENABLE_HI, 8'h00);
        rd(sfr_pkg::ADDR_FLAG_LO, 8'h06);
        rd(sfr_pkg::ADDR_FLAG_HI, 8'h00);
        idle(2);
        $display("test reset values done");
        wr(sfr_pkg::ADDR_ENABLE_LO, 8'hFF);
        rd(sfr_pkg::ADDR_ENABLE_LO, 8'h33);
        wr(sfr_pkg::ADDR_ENABLE_HI, 8'hFF);
        wr(sfr_pkg::ADDR_FLAG_HI, 8'hFF);
        rd(sfr_pkg::ADDR_ENABLE_HI, 8'h00);
        rd(sfr_pkg::ADDR_FLAG_HI, 8'h00);
        wr(sfr_pkg::ADDR_FLAG_LO, 8'hFF);
        rd(sfr_pkg::ADDR_FLAG_LO, 8'h1F);
        wr(sfr_pkg::ADDR_FLAG_LO, 8'h00);
        rd(sfr_pkg::ADDR_FLAG_LO, 8'h00);
        wr(sfr_pkg::ADDR_ENABLE_LO, 8'h00);
        rd(8'h40, 8'h00);
        $display("test access kinds done");
        for (int i = 0; i < 4; i++)
        begin
            pulse(ev_tab[i]);
            idle(4);
            rd(sfr_pkg::ADDR_FLAG_LO, {3'b000, ev_tab[i]});
            wr(sfr_pkg::ADDR_FLAG_LO, 8'h00);
            rd(sfr_pkg::ADDR_FLAG_LO, 8'h00);
        end
        // hardware set and software clear in the same cycle
        hw_ev <= 5'h10;
        wr(sfr_pkg::ADDR_FLAG_LO, 8'h00);
        hw_ev <= 5'h00;
        rd(sfr_pkg::ADDR_FLAG_LO, 8'h10);
        idle(2);
        $display("test hardware flags done");
        wr(sfr_pkg::ADDR_FLAG_LO, 8'h1F);
        wr(sfr_pkg::ADDR_ENABLE_LO, 8'h33);
        reset_pulse(1'b1, 1'b0);
        rd(sfr_pkg::ADDR_FLAG_LO, 8'h0F);
        rd(sfr_pkg::ADDR_ENABLE_LO, 8'h00);
        wr(sfr_pkg::ADDR_FLAG_LO, 8'h1F);
        reset_pulse(1'b0, 1'b1);
        rd(sfr_pkg::ADDR_FLAG_LO, 8'h06);
        settle();
        check_bit(nmi_req_o, 1'b0);
        $display("test reset kinds done");
        for (int i = 0; i < 3; i++)
        begin
            wr(sfr_pkg::ADDR_FLAG_LO, fl_tab[i]);
            flash_i <= (i == 2);
            wr(sfr_pkg::ADDR_ENABLE_LO, en_tab[i]);
            settle();
            check_bit(nmi_req_o, 1'b1);
            wr(sfr_pkg::ADDR_ENABLE_LO, 8'h33 & ~en_tab[i]);
            settle();
            check_bit(nmi_req_o, 1'b0);
        end
        flash_i <= 1'b0;
        $display("test nmi gating done");
        wr(sfr_pkg::ADDR_ENABLE_LO, 8'h01);
        wr(sfr_pkg::ADDR_FLAG_LO, 8'h01);
        mode_i <= 1'b1;
        settle();
        check_bit(wdog_irq_o, 1'b1);
        mode_i <= 1'b0;
        settle();
        check_bit(wdog_irq_o, 1'b0);
        check_bit(nmi_req_o, 1'b0);
        mode_i <= 1'b1;
        $display("test watchdog gating done");
        wr(sfr_pkg::ADDR_IRQ_CLEAR, 8'h0F);
        wr(sfr_pkg::ADDR_IRQ_STATUS, 8'hFF);
        rd(sfr_pkg::ADDR_IRQ_STATUS, 8'h00);
        wr(sfr_pkg::ADDR_IRQ_ENABLE, 8'h0F);
        rd(sfr_pkg::ADDR_IRQ_ENABLE, 8'h0F);
        pulse(5'h02);
        settle();
        check_bit(irq_o, 1'b1);
        rd(sfr_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(sfr_pkg::ADDR_IRQ_ENABLE, 8'h0E);
        settle();
        check_bit(irq_o, 1'b0);
        wr(sfr_pkg::ADDR_IRQ_CLEAR, 8'h01);
        wr(sfr_pkg::ADDR_IRQ_ENABLE, 8'h0F);
        rd(sfr_pkg::ADDR_IRQ_STATUS, 8'h00);
        settle();
        check_bit(irq_o, 1'b0);
        $display("test event interrupt done");
        for (int i = 0; i < 16; i++)
        begin
            d = 8'($urandom);
            a = ($urandom % 2 == 0) ? sfr_pkg::ADDR_ENABLE_LO : sfr_pkg::ADDR_FLAG_LO;
            wr(a, d);
            rd(a, d & ((a == sfr_pkg::ADDR_FLAG_LO) ? 8'h1F : 8'h33));
        end
        idle(4);
        $display("test random access done");
        wrap_up();
    end
endmodule : system_interrupt_enable_flag_regs_tb
